// ---- rtl/oag_top.sv ----
// Operand address generator: sequences memory accesses per addressing mode
`timescale 1ns/10ps
module oag_top
  import oag_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire oag_mode_t  mode,
  input  wire oag_op_t    op,
  input  wire logic       src_sel_idx,
  input  wire logic       reg_space,
  input  wire logic       load_idx,
  input  wire logic [7:0] operand1,
  input  wire logic [7:0] operand2,
  input  wire logic [7:0] mem_rdata,
  input  wire logic       acc_wr,
  input  wire logic [7:0] acc_wdata,
  input  wire logic       idx_wr,
  input  wire logic [7:0] idx_wdata,
  output logic            busy_ff,
  output logic            done_ff,
  output logic            illegal_ff,
  output logic [1:0]      length_ff,
  output logic            mem_rd_ff,
  output logic            mem_wr_ff,
  output logic            mem_reg_ff,
  output logic [7:0]      mem_addr_ff,
  output logic [7:0]      mem_wdata_ff,
  output logic [7:0]      acc_ff,
  output logic [7:0]      idx_ff
);

  // Sequencer states; every memory access takes exactly one cycle
  typedef enum logic [2:0] {
    OAG_ST_IDLE,
    OAG_ST_RD_DST,
    OAG_ST_RD_PTR,
    OAG_ST_RD_DATA,
    OAG_ST_WR_DATA,
    OAG_ST_WR_PTR,
    OAG_ST_DONE
  } oag_state_t;

  // Captured instruction and working values
  oag_state_t  state_ff;
  oag_state_t  nxt_state;
  oag_mode_t   mode_ff;
  oag_op_t     op_ff;
  logic        reg_ff;
  logic        load_idx_ff;
  logic [7:0]  op1_ff;
  logic [7:0]  op2_ff;
  logic [7:0]  ptr_ff;
  logic [7:0]  src_val_ff;
  logic [7:0]  dst_addr;
  logic [1:0]  dec_len;
  oag_src_t    dec_src;
  logic        dec_legal;
  logic        dec_mem_dest;
  logic [7:0]  src_val;
  logic [7:0]  alu_out;
  logic        is_indexed;
  // Live view of the instruction for the first access of a run, captured view for the rest
  oag_mode_t   cur_mode;
  logic [7:0]  cur_op1;
  logic [7:0]  cur_op2;
  logic [7:0]  cur_src_val;
  logic        cur_reg;

  oag_decode u_decode (
    .mode        (mode),
    .op          (op),
    .src_sel_idx (src_sel_idx),
    .length      (dec_len),
    .src         (dec_src),
    .legal       (dec_legal),
    .mem_dest    (dec_mem_dest)
  );

  oag_alu u_alu (
    .op      (op_ff),
    .src_val (src_val_ff),
    .dst_val (mem_rdata),
    .result  (alu_out)
  );

  // Indexed modes add the eight-bit index register to operand one; the sum
  // wraps at eight bits so an indexed access never leaves its space
  assign is_indexed = (cur_mode == OAG_M_DST_IDX) || (cur_mode == OAG_M_DST_IDX_IMM) ||
                      (cur_mode == OAG_M_SRC_IDX_REG);
  assign dst_addr   = is_indexed ? oag_add8(cur_op1, idx_ff) : cur_op1; // RULE5 RULE9 RULE16

  // Source operand value captured at start
  always_comb begin
    case (dec_src)
      OAG_S_ACC: src_val = acc_ff;
      OAG_S_IDX: src_val = idx_ff;
      OAG_S_IMM: src_val = operand2;
      default:   src_val = 8'h00;
    endcase
  end

  // The first access is launched at the same edge that captures the
  // instruction, so while idle the live inputs stand in for the copies
  always_comb begin
    if (state_ff == OAG_ST_IDLE) begin
      cur_mode    = mode;
      cur_op1     = operand1;
      cur_op2     = operand2;
      cur_src_val = src_val;
      cur_reg     = reg_space && (mode != OAG_M_DIR_DIR); // RULE10
    end else begin
      cur_mode    = mode_ff;
      cur_op1     = op1_ff;
      cur_op2     = op2_ff;
      cur_src_val = src_val_ff;
      cur_reg     = reg_ff;
    end
  end

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      OAG_ST_IDLE: begin
        if (start && dec_legal) begin
          if (mode == OAG_M_SRC_IND_INC || mode == OAG_M_DST_IND_INC) begin
            nxt_state = OAG_ST_RD_PTR;
          end else if (mode == OAG_M_DIR_DIR || mode == OAG_M_SRC_IDX_REG) begin
            nxt_state = OAG_ST_RD_DATA;
          end else if (op == OAG_OP_ARITH && dec_mem_dest) begin
            nxt_state = OAG_ST_RD_DST;
          end else begin
            nxt_state = OAG_ST_WR_DATA;
          end
        end else if (start) begin
          // Refused combination: no access at all, straight to done
          nxt_state = OAG_ST_DONE;
        end
      end
      OAG_ST_RD_DST:  nxt_state = OAG_ST_WR_DATA;
      OAG_ST_RD_PTR: begin
        nxt_state = (mode_ff == OAG_M_SRC_IND_INC) ? OAG_ST_RD_DATA : OAG_ST_WR_DATA;
      end
      OAG_ST_RD_DATA: begin
        if (mode_ff == OAG_M_SRC_IND_INC) begin
          nxt_state = OAG_ST_WR_PTR;
        end else if (mode_ff == OAG_M_DIR_DIR) begin
          nxt_state = OAG_ST_WR_DATA;
        end else begin
          nxt_state = OAG_ST_DONE;
        end
      end
      OAG_ST_WR_DATA: begin
        nxt_state = (mode_ff == OAG_M_DST_IND_INC) ? OAG_ST_WR_PTR : OAG_ST_DONE;
      end
      OAG_ST_WR_PTR:  nxt_state = OAG_ST_DONE;
      OAG_ST_DONE:    nxt_state = OAG_ST_IDLE;
      default:        nxt_state = OAG_ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= OAG_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Instruction capture at start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_ff     <= OAG_M_NONE;
      op_ff       <= OAG_OP_OTHER;
      reg_ff      <= 1'b0;
      load_idx_ff <= 1'b0;
      op1_ff      <= 8'h00;
      op2_ff      <= 8'h00;
      src_val_ff  <= 8'h00;
      length_ff   <= OAG_LEN_ONE;
      illegal_ff  <= 1'b0;
    end else if (state_ff == OAG_ST_IDLE && start) begin
      mode_ff     <= mode;
      op_ff       <= op;
      reg_ff      <= cur_reg; // RULE10
      load_idx_ff <= load_idx;
      op1_ff      <= operand1;
      op2_ff      <= operand2;
      src_val_ff  <= src_val;
      length_ff   <= dec_len; // RULE4 RULE8 RULE10 RULE14
      illegal_ff  <= !dec_legal; // RULE10 RULE14
    end
  end

  // Pointer capture from memory; read data is taken at the edge that ends
  // the read strobe, so the memory must answer within that cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ptr_ff <= 8'h00;
    end else if (state_ff == OAG_ST_RD_PTR) begin
      ptr_ff <= mem_rdata;
    end
  end

  // Memory access outputs per state
  // Strobes stand one cycle; address and data hold their last value between
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_reg_ff   <= 1'b0;
      mem_addr_ff  <= 8'h00;
      mem_wdata_ff <= 8'h00;
    end else begin
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_reg_ff   <= cur_reg;
      case (nxt_state)
        OAG_ST_RD_DST: begin
          mem_rd_ff   <= 1'b1;
          mem_addr_ff <= dst_addr; // RULE3
        end
        OAG_ST_RD_PTR: begin
          mem_rd_ff   <= 1'b1;
          mem_reg_ff  <= 1'b0;
          mem_addr_ff <= cur_op1;
        end
        OAG_ST_RD_DATA: begin
          mem_rd_ff <= 1'b1;
          if (cur_mode == OAG_M_SRC_IND_INC) begin
            mem_reg_ff  <= 1'b0;
            mem_addr_ff <= mem_rdata; // RULE11
          end else if (cur_mode == OAG_M_DIR_DIR) begin
            mem_addr_ff <= cur_op2; // RULE10
          end else begin
            mem_addr_ff <= dst_addr; // RULE15
          end
        end
        OAG_ST_WR_DATA: begin
          mem_wr_ff <= 1'b1;
          if (cur_mode == OAG_M_DST_IND_INC) begin
            mem_reg_ff   <= 1'b0;
            mem_addr_ff  <= mem_rdata; // RULE13
            mem_wdata_ff <= acc_ff; // RULE13
          end else if (cur_mode == OAG_M_DIR_DIR) begin
            mem_addr_ff  <= cur_op1; // RULE10
            mem_wdata_ff <= mem_rdata;
          end else begin
            mem_addr_ff  <= dst_addr; // RULE1 RULE5 RULE9
            mem_wdata_ff <= (state_ff == OAG_ST_RD_DST) ? alu_out : cur_src_val; // RULE3
          end
        end
        OAG_ST_WR_PTR: begin
          mem_wr_ff    <= 1'b1;
          mem_reg_ff   <= 1'b0;
          mem_addr_ff  <= op1_ff;
          mem_wdata_ff <= oag_add8(ptr_ff, OAG_PTR_STEP); // RULE12 RULE17
        end
        default: begin
          mem_reg_ff <= 1'b0;
        end
      endcase
    end
  end

  // Accumulator: of the modes only source-indirect loads it; memory results leave it alone
  // External loads are honoured only while idle so a run sees fixed values
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_ff <= OAG_ACC_RST;
    end else if (state_ff == OAG_ST_RD_DATA && mode_ff == OAG_M_SRC_IND_INC) begin
      acc_ff <= mem_rdata; // RULE11 RULE7
    end else if (acc_wr && state_ff == OAG_ST_IDLE) begin
      acc_ff <= acc_wdata;
    end
  end

  // Index register, optionally loaded from an indexed register read
  // As with the accumulator, external loads wait for idle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idx_ff <= OAG_IDX_RST;
    end else if (state_ff == OAG_ST_RD_DATA && mode_ff == OAG_M_SRC_IDX_REG && load_idx_ff) begin
      idx_ff <= mem_rdata; // RULE15
    end else if (idx_wr && state_ff == OAG_ST_IDLE) begin
      idx_ff <= idx_wdata;
    end
  end

  // Status outputs; busy covers the done cycle, so a new start waits for idle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != OAG_ST_IDLE);
      done_ff <= (nxt_state == OAG_ST_DONE);
    end
  end

endmodule // oag_top

// ---- rtl/oag_pkg.sv ----
// Constants and types for the operand address generator
// Function
// [RULE1] Destination direct writes at operand one address
// [RULE2] Destination direct source is accumulator or index
// [RULE3] Arithmetic uses destination contents as second source
// [RULE4] Destination direct and indexed are two bytes
// [RULE5] Destination indexed address is operand plus index
// [RULE6] Destination indexed source is always accumulator
// [RULE7] Memory result leaves accumulator unchanged
// [RULE8] Immediate destination modes: operand two, three bytes
// [RULE9] Indexed immediate writes at index plus operand
// [RULE10] Direct to direct only copy, three bytes
// [RULE11] Indirect source loads pointed byte into accumulator
// [RULE12] Indirect modes increment stored pointer in memory
// [RULE13] Indirect destination stores accumulator at pointer
// [RULE14] Indirect modes only indirect move, two bytes
// [RULE15] Indexed register read may load index register
// [RULE16] Index register is eight bit offset
// [RULE17] Address sums and increments wrap modulo 256
package oag_pkg;

  typedef enum logic [3:0] {
    OAG_M_NONE,
    OAG_M_DST_DIR,
    OAG_M_DST_IDX,
    OAG_M_DST_DIR_IMM,
    OAG_M_DST_IDX_IMM,
    OAG_M_DIR_DIR,
    OAG_M_SRC_IND_INC,
    OAG_M_DST_IND_INC,
    OAG_M_SRC_IDX_REG
  } oag_mode_t;

  typedef enum logic [1:0] {
    OAG_OP_OTHER,
    OAG_OP_ARITH,
    OAG_OP_COPY,
    OAG_OP_INDIRECT_MOVE
  } oag_op_t;

  typedef enum logic [1:0] {
    OAG_S_ACC,
    OAG_S_IDX,
    OAG_S_IMM,
    OAG_S_MEM
  } oag_src_t;

  localparam logic [7:0] OAG_ACC_RST    = 8'h00;
  localparam logic [7:0] OAG_IDX_RST    = 8'h00;
  localparam logic [1:0] OAG_LEN_ONE    = 2'h1;
  localparam logic [1:0] OAG_LEN_TWO    = 2'h2;
  localparam logic [1:0] OAG_LEN_THREE  = 2'h3;
  localparam logic [7:0] OAG_PTR_STEP   = 8'h01;

  // Eight-bit address sum, wraps modulo 256
  function automatic logic [7:0] oag_add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0]; // RULE17
  endfunction

endpackage

// ---- rtl/oag_decode.sv ----
// Mode decode: instruction length, source choice and legality
`timescale 1ns/10ps
module oag_decode
  import oag_pkg::*;
(
  input  wire oag_mode_t  mode,
  input  wire oag_op_t    op,
  input  wire logic       src_sel_idx,
  output logic [1:0]      length,
  output oag_src_t        src,
  output logic            legal,
  output logic            mem_dest
);

  // Length, source and legality per mode
  always_comb begin
    length   = OAG_LEN_ONE;
    src      = OAG_S_ACC;
    legal    = 1'b1;
    mem_dest = 1'b0;
    case (mode)
      OAG_M_DST_DIR: begin
        length   = OAG_LEN_TWO; // RULE4
        src      = src_sel_idx ? OAG_S_IDX : OAG_S_ACC; // RULE2
        mem_dest = 1'b1;
      end
      OAG_M_DST_IDX: begin
        length   = OAG_LEN_TWO; // RULE4
        src      = OAG_S_ACC; // RULE6
        mem_dest = 1'b1;
      end
      OAG_M_DST_DIR_IMM, OAG_M_DST_IDX_IMM: begin
        length   = OAG_LEN_THREE; // RULE8
        src      = OAG_S_IMM; // RULE8
        mem_dest = 1'b1;
      end
      OAG_M_DIR_DIR: begin
        length   = OAG_LEN_THREE; // RULE10
        src      = OAG_S_MEM;
        legal    = (op == OAG_OP_COPY); // RULE10
        mem_dest = 1'b1;
      end
      OAG_M_SRC_IND_INC: begin
        length   = OAG_LEN_TWO; // RULE14
        src      = OAG_S_MEM;
        legal    = (op == OAG_OP_INDIRECT_MOVE); // RULE14
      end
      OAG_M_DST_IND_INC: begin
        length   = OAG_LEN_TWO; // RULE14
        src      = OAG_S_ACC;
        legal    = (op == OAG_OP_INDIRECT_MOVE); // RULE14
        mem_dest = 1'b1;
      end
      OAG_M_SRC_IDX_REG: begin
        length   = OAG_LEN_TWO;
        src      = OAG_S_MEM;
      end
      default: begin
        legal    = 1'b0;
      end
    endcase
  end

endmodule // oag_decode

// ---- rtl/oag_alu.sv ----
// Small operand combiner: arithmetic add or pass of the source
`timescale 1ns/10ps
module oag_alu
  import oag_pkg::*;
(
  input  wire oag_op_t    op,
  input  wire logic [7:0] src_val,
  input  wire logic [7:0] dst_val,
  output logic [7:0]      result
);

  // Arithmetic takes the destination contents as second operand
  always_comb begin
    if (op == OAG_OP_ARITH) begin
      result = oag_add8(src_val, dst_val); // RULE3
    end else begin
      result = src_val;
    end
  end

endmodule // oag_alu

// ---- bench/oag_top_asserts.sv ----
// Concurrent checks on the operand address generator ports
`timescale 1ns/10ps
module oag_top_asserts
  import oag_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       start,
  input wire oag_mode_t  mode,
  input wire oag_op_t    op,
  input wire logic       src_sel_idx,
  input wire logic [7:0] operand1,
  input wire logic       busy_ff,
  input wire logic       illegal_ff,
  input wire logic [1:0] length_ff,
  input wire logic       mem_rd_ff,
  input wire logic       mem_wr_ff,
  input wire logic       mem_reg_ff,
  input wire logic [7:0] mem_addr_ff,
  input wire logic [7:0] mem_wdata_ff,
  input wire logic [7:0] acc_ff,
  input wire logic [7:0] idx_ff
);
  logic [7:0] op1_cap_ff;
  logic       sel_cap_ff;
  wire        take = start && !busy_ff;
  // Operands held from the accepting edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op1_cap_ff <= 8'h00;
      sel_cap_ff <= 1'b0;
    end else if (take) begin
      op1_cap_ff <= operand1;
      sel_cap_ff <= src_sel_idx;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_len_two_dst: assert property (take && mode inside {OAG_M_DST_DIR, OAG_M_DST_IDX}
    |=> length_ff == OAG_LEN_TWO) else $error("dest length not two");
  chk_len_three_imm: assert property (take && mode inside {OAG_M_DST_DIR_IMM, OAG_M_DST_IDX_IMM}
    |=> length_ff == OAG_LEN_THREE) else $error("immediate length not three");
  chk_copy_legal: assert property (take && mode == OAG_M_DIR_DIR && op == OAG_OP_COPY
    |=> !illegal_ff && length_ff == OAG_LEN_THREE) else $error("copy direct mode refused");
  chk_copy_only: assert property (take && mode == OAG_M_DIR_DIR && op != OAG_OP_COPY
    |=> illegal_ff) else $error("direct mode accepted without copy");
  chk_ind_only: assert property (take && mode inside {OAG_M_SRC_IND_INC, OAG_M_DST_IND_INC}
    |=> illegal_ff == (op != OAG_OP_INDIRECT_MOVE)) else $error("indirect legality wrong");
  chk_illegal_quiet: assert property (illegal_ff && busy_ff |-> !mem_rd_ff && !mem_wr_ff)
    else $error("memory access on refused instruction");
  chk_dst_dir_wr: assert property (take && mode == OAG_M_DST_DIR && op == OAG_OP_COPY
    |-> ##[1:2] mem_wr_ff && mem_addr_ff == op1_cap_ff
    && mem_wdata_ff == (sel_cap_ff ? idx_ff : acc_ff)) else $error("direct write wrong");
  chk_dst_idx_wr: assert property (take && mode == OAG_M_DST_IDX && op == OAG_OP_COPY
    |-> ##[1:2] mem_wr_ff && mem_addr_ff == op1_cap_ff + idx_ff
    && mem_wdata_ff == acc_ff) else $error("indexed write wrong");
  chk_ind_ptr_rd: assert property (take && mode inside {OAG_M_SRC_IND_INC, OAG_M_DST_IND_INC}
    && op == OAG_OP_INDIRECT_MOVE |-> ##[1:2] mem_rd_ff && mem_addr_ff == op1_cap_ff
    && !mem_reg_ff) else $error("pointer read wrong");
  chk_acc_kept: assert property (take && mode inside {OAG_M_DST_DIR, OAG_M_DST_IDX}
    |=> $stable(acc_ff) [*3]) else $error("accumulator changed");
endmodule // oag_top_asserts

bind oag_top oag_top_asserts oag_top_asserts_inst (.core_clk, .rst, .start, .mode, .op,
  .src_sel_idx, .operand1, .busy_ff, .illegal_ff, .length_ff, .mem_rd_ff, .mem_wr_ff,
  .mem_reg_ff, .mem_addr_ff, .mem_wdata_ff, .acc_ff, .idx_ff);

// ---- bench/operand_address_generator_tb.sv ----
// Random instruction bench for the operand address generator
`timescale 1ns/10ps
module operand_address_generator_tb;
  import oag_pkg::*;
  logic core_clk, rst, start, src_sel_idx, reg_space, load_idx, acc_wr, idx_wr;
  logic busy_ff, done_ff, illegal_ff, mem_rd_ff, mem_wr_ff, mem_reg_ff;
  oag_mode_t   mode;
  oag_op_t     op;
  logic [7:0]  operand1, operand2, mem_rdata, acc_wdata, idx_wdata;
  logic [7:0]  mem_addr_ff, mem_wdata_ff, acc_ff, idx_ff, exp_acc, exp_idx;
  logic [1:0]  length_ff, exp_len;
  logic        exp_ill;
  logic [7:0]  reg_keep;
  logic [7:0]  ram [512];
  logic [17:0] log_q [$];
  logic [17:0] exp_q [$];
  int          fail_count, check_count, cyc;

  oag_top oag_top_inst (.core_clk, .rst, .start, .mode, .op, .src_sel_idx, .reg_space,
    .load_idx, .operand1, .operand2, .mem_rdata, .acc_wr, .acc_wdata, .idx_wr, .idx_wdata,
    .busy_ff, .done_ff, .illegal_ff, .length_ff, .mem_rd_ff, .mem_wr_ff, .mem_reg_ff,
    .mem_addr_ff, .mem_wdata_ff, .acc_ff, .idx_ff);

  // Clock and hang guard
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  // Memory model: strobes logged at the edge ending them; read data stands
  // through the strobe cycle itself, scrambled outside it
  always @(posedge core_clk) begin
    if (mem_wr_ff === 1'b1) begin
      ram[{mem_reg_ff, mem_addr_ff}] <= mem_wdata_ff;
      log_q.push_back({1'b1, mem_reg_ff, mem_addr_ff, mem_wdata_ff});
    end
    if (mem_rd_ff === 1'b1) begin
      log_q.push_back({1'b0, mem_reg_ff, mem_addr_ff, 8'h00});
    end
    #1;
    if (mem_rd_ff === 1'b1) begin
      mem_rdata = ram[{mem_reg_ff, mem_addr_ff}];
    end else begin
      mem_rdata = ~mem_rdata;
    end
  end

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Expected access list and register values from the current inputs
  task automatic build_exp();
    logic [7:0] ad, p, s;
    exp_q.delete();
    exp_acc = acc_wdata;
    exp_idx = idx_wdata;
    ad = (mode inside {OAG_M_DST_IDX, OAG_M_DST_IDX_IMM, OAG_M_SRC_IDX_REG}) ?
         operand1 + idx_wdata : operand1;
    s = (mode inside {OAG_M_DST_DIR_IMM, OAG_M_DST_IDX_IMM}) ? operand2 :
        (mode == OAG_M_DST_DIR && src_sel_idx) ? idx_wdata : acc_wdata;
    p = ram[{1'b0, operand1}];
    exp_ill = (mode == OAG_M_DIR_DIR && op != OAG_OP_COPY) ||
              (mode inside {OAG_M_SRC_IND_INC, OAG_M_DST_IND_INC} && op != OAG_OP_INDIRECT_MOVE);
    exp_len = (mode inside {OAG_M_DST_DIR_IMM, OAG_M_DST_IDX_IMM, OAG_M_DIR_DIR}) ?
              OAG_LEN_THREE : OAG_LEN_TWO;
    if (exp_ill) return;
    case (mode)
      OAG_M_DIR_DIR: begin
        exp_q.push_back({2'b00, operand2, 8'h00});
        exp_q.push_back({2'b10, operand1, ram[{1'b0, operand2}]});
      end
      OAG_M_SRC_IND_INC: begin
        exp_q.push_back({2'b00, operand1, 8'h00});
        exp_q.push_back({2'b00, p, 8'h00});
        exp_q.push_back({2'b10, operand1, p + 8'h01});
        exp_acc = ram[{1'b0, p}];
      end
      OAG_M_DST_IND_INC: begin
        exp_q.push_back({2'b00, operand1, 8'h00});
        exp_q.push_back({2'b10, p, acc_wdata});
        exp_q.push_back({2'b10, operand1, p + 8'h01});
      end
      OAG_M_SRC_IDX_REG: begin
        exp_q.push_back({2'b01, ad, 8'h00});
        if (load_idx) exp_idx = ram[{1'b1, ad}];
      end
      default: begin
        if (op == OAG_OP_ARITH) begin
          exp_q.push_back({1'b0, reg_space, ad, 8'h00});
          s = s + ram[{reg_space, ad}];
        end
        exp_q.push_back({1'b1, reg_space, ad, s});
      end
    endcase
  endtask

  // Load registers, issue one instruction, compare the outcome
  task automatic run_one();
    int n;
    build_exp();
    @(posedge core_clk);
    #1 acc_wr = 1'b1;
    idx_wr = 1'b1;
    @(posedge core_clk);
    #1 {acc_wr, idx_wr} = 2'b00;
    start = 1'b1;
    log_q.delete();
    @(posedge core_clk);
    #1 start = 1'b0;
    n = 0;
    while (done_ff !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(done_ff, 18'h1);
    chk(busy_ff, 18'h1);
    chk(illegal_ff, exp_ill);
    if (!exp_ill) chk(length_ff, exp_len);
    chk(18'(log_q.size()), 18'(exp_q.size()));
    foreach (exp_q[i]) if (i < log_q.size()) chk(log_q[i], exp_q[i]);
    @(posedge core_clk);
    #1 chk(acc_ff, exp_acc);
    chk(idx_ff, exp_idx);
    chk({done_ff, busy_ff}, 18'h0);
  endtask

  initial begin
    void'($urandom(64176));
    {start, src_sel_idx, reg_space, load_idx, acc_wr, idx_wr} = 6'h00;
    {operand1, operand2, mem_rdata, acc_wdata, idx_wdata} = 40'h0;
    mode = OAG_M_NONE;
    op = OAG_OP_OTHER;
    foreach (ram[i]) ram[i] = 8'($urandom());
    rst = 1'b1;
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    chk(acc_ff, OAG_ACC_RST);
    chk(idx_ff, OAG_IDX_RST);
    for (int i = 0; i < 300; i++) begin
      mode = oag_mode_t'(4'($urandom_range(8, 1)));
      case (mode)
        OAG_M_DIR_DIR: op = ($urandom_range(3, 0) == 0) ? OAG_OP_ARITH : OAG_OP_COPY;
        OAG_M_SRC_IND_INC, OAG_M_DST_IND_INC: begin
          op = ($urandom_range(3, 0) == 0) ? OAG_OP_COPY : OAG_OP_INDIRECT_MOVE;
        end
        OAG_M_SRC_IDX_REG: op = OAG_OP_COPY;
        default: op = $urandom_range(1, 0) ? OAG_OP_ARITH : OAG_OP_COPY;
      endcase
      reg_space = (mode == OAG_M_SRC_IDX_REG) ? 1'b1 :
                  (mode inside {OAG_M_SRC_IND_INC, OAG_M_DST_IND_INC}) ? 1'b0 : 1'($urandom());
      {src_sel_idx, load_idx} = 2'($urandom());
      {operand1, operand2, acc_wdata, idx_wdata} = 32'($urandom());
      // Wrap corner: top offset, top index, pointer at the last address
      if (i % 8 == 0) begin
        {operand1, idx_wdata} = 16'hffff;
        ram[{1'b0, 8'hff}] = 8'hff;
      end
      reg_keep = ram[{1'b1, operand1}];
      run_one();
      if (mode == OAG_M_DIR_DIR) chk(ram[{1'b1, operand1}], reg_keep);
    end
    end_sim();
  end
endmodule // operand_address_generator_tb
